// *** verilog/cmd_decoder_pkg.sv ***
package cmd_decoder_pkg;

    // ==========================================================
    // Register map, byte addresses on the APB side.
    // ==========================================================
    localparam logic [7:0] OFS_CMD = 8'h00;       // Write: command byte, select low.
    localparam logic [7:0] OFS_PARAM = 8'h04;     // Write: parameter byte, select high.
    localparam logic [7:0] OFS_MEMDATA = 8'h08;   // Write: display memory data byte.
    localparam logic [7:0] OFS_STATUS = 8'h0C;    // Read: decoder status.
    localparam logic [7:0] OFS_SET_A = 8'h10;     // Read: first settings word.
    localparam logic [7:0] OFS_SET_B = 8'h14;     // Read: second settings word.
    localparam logic [7:0] OFS_TABLE = 8'h40;     // Read: gray table, one word per level.
    localparam logic [7:0] OFS_TABLE_END = 8'h7C; // Last word of the gray table window.

    // ==========================================================
    // Status word field positions.
    // ==========================================================
    localparam int ST_LOCK = 0;      // Command lock state.
    localparam int ST_CUSTOM = 1;    // Custom table in use.
    localparam int ST_BUSY = 2;      // Parameters still expected.
    localparam int ST_RANGE = 3;     // A loaded gray width was above the limit.
    localparam int ST_ORDER = 4;     // Loaded gray widths were not increasing.

    // ==========================================================
    // Command codes.
    // ==========================================================
    localparam logic [7:0] CMD_TABLE_ON = 8'h00;
    localparam logic [7:0] CMD_PRECHARGE2 = 8'hB6;
    localparam logic [7:0] CMD_GRAY_TABLE = 8'hB8;
    localparam logic [7:0] CMD_LINEAR = 8'hB9;
    localparam logic [7:0] CMD_PRE_VOLT = 8'hBB;
    localparam logic [7:0] CMD_DESELECT = 8'hBE;
    localparam logic [7:0] CMD_SEG_CURRENT = 8'hC1;
    localparam logic [7:0] CMD_MASTER = 8'hC7;
    localparam logic [7:0] CMD_MUX = 8'hCA;
    localparam logic [7:0] CMD_ENHANCE = 8'hD1;
    localparam logic [7:0] CMD_LOCK = 8'hFD;

    // ==========================================================
    // Reset values, limits and table figures.
    // ==========================================================
    localparam logic [3:0] RST_PRECHARGE2 = 4'h8;
    localparam logic [4:0] RST_PRE_VOLT = 5'h17;
    localparam logic [3:0] RST_DESELECT = 4'h4;
    localparam logic [7:0] RST_SEG_CURRENT = 8'h7F;
    localparam logic [3:0] RST_MASTER = 4'hF;
    localparam logic [6:0] RST_MUX = 7'h7F;
    localparam logic [6:0] MUX_MIN = 7'h0F;
    localparam logic [1:0] RST_ENHANCE = 2'h2;
    localparam logic [1:0] ENHANCE_RESERVED = 2'h0;
    localparam int ENHANCE_LSB = 4;
    localparam logic [7:0] LOCK_FIXED = 8'h12;
    localparam int LOCK_BIT = 2;
    localparam logic [7:0] GRAY_MAX = 8'hB4;
    localparam int GRAY_LEVELS = 15;
    localparam logic [7:0] LINEAR_STEP = 8'h08;

    // ==========================================================
    // Settings carried to the display logic as one bundle.
    // ==========================================================
    typedef struct packed {
        logic [3:0] precharge2;
        logic [4:0] pre_volt;
        logic [3:0] com_deselect_level;
        logic [7:0] segment_drive_current;
        logic [3:0] master_contrast;
        logic [6:0] mux_ratio;
        logic [1:0] enhance;
        logic custom_table;
        logic locked;
    } settings_type;

endpackage

// *** verilog/gray_table_mem.sv ***
`timescale 1ns/1ps
// Small table memory: one write port, two read ports, registered read data.
module gray_table_mem #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [$clog2(DEPTH)-1:0] rd_addr_a,
    output logic [WIDTH-1:0] rd_data_a,
    input wire logic [$clog2(DEPTH)-1:0] rd_addr_b,
    output logic [WIDTH-1:0] rd_data_b
);

    // ==========================================================
    // Storage.
    // ==========================================================
    logic [WIDTH-1:0] mem_r [DEPTH]; // Table words, entry 0 unused by the decoder.

    // Writes land on the clock edge; entries start at zero after reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
        end else if (wr_en) begin
            mem_r[wr_addr] <= wr_data;
        end
    end

    // Both read ports return data one edge after the address.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data_a <= '0;
            rd_data_b <= '0;
        end else begin
            rd_data_a <= mem_r[rd_addr_a];
            rd_data_b <= mem_r[rd_addr_b];
        end
    end

endmodule

// *** verilog/gray_width_select.sv ***
`timescale 1ns/1ps
// Chooses the pulse width for a gray level from the linear or custom table.
module gray_width_select (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic custom_table,
    input wire logic [3:0] level,
    input wire logic [7:0] custom_width,
    output logic [7:0] width_r
);

    // ==========================================================
    // Width pipeline.
    // ==========================================================
    logic [3:0] level_d_r; // Level delayed to line up with memory read data.
    logic custom_d_r;      // Table choice delayed likewise.

    // Linear table: levels 0 and 1 are zero wide, then 8 clocks per level.
    function automatic logic [7:0] linear_width(input logic [3:0] lvl);
        logic [7:0] steps;
        steps = {4'h0, lvl} - 8'h01;
        if (lvl < 4'h2) begin
            return 8'h00;
        end
        return 8'((steps * cmd_decoder_pkg::LINEAR_STEP) & 8'hFF);
    endfunction

    // Delay the request by one edge, matching the registered memory read.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_d_r <= 4'h0;
            custom_d_r <= 1'b0;
        end else begin
            level_d_r <= level;
            custom_d_r <= custom_table;
        end
    end

    // Register the chosen width; level 0 is always zero wide.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            width_r <= 8'h00;
        end else if (custom_d_r && level_d_r != 4'h0) begin
            width_r <= custom_width;
        end else begin
            width_r <= linear_width(level_d_r);
        end
    end

endmodule

// *** verilog/oled_driver_config_command_decoder.sv ***
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
// Configuration command decoder reached over APB.
module oled_driver_config_command_decoder #(
    parameter int GRAY_LEVELS = cmd_decoder_pkg::GRAY_LEVELS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [3:0] gray_level,
    output logic [7:0] gray_level_width,
    output cmd_decoder_pkg::settings_type settings,
    output logic [7:0] mem_data,
    output logic mem_data_valid
);

    // ==========================================================
    // Elaboration check.
    // ==========================================================
    // The table memory and the level port hold exactly fifteen levels.
    if (GRAY_LEVELS != cmd_decoder_pkg::GRAY_LEVELS) begin : g_bad_levels
        $error("GRAY_LEVELS must match the fifteen-level table");
    end

    // ==========================================================
    // Declarations.
    // ==========================================================
    typedef enum logic [1:0] {
        IDLE,       // No parameters expected.
        PARAMS,     // Collecting parameters of the held command.
        DISCARD     // Extra parameters are dropped.
    } parse_state_type;

    parse_state_type state_r;            // Parser state.
    logic [7:0] cmd_r;                   // Command whose parameters are expected.
    logic [3:0] count_r;                 // Parameters taken so far.
    logic [3:0] precharge2_r;            // Second pre-charge period.
    logic [4:0] pre_volt_r;              // Pre-charge voltage code.
    logic [3:0] deselect_r;              // Common-line deselect level code.
    logic [7:0] seg_current_r;           // Segment drive current.
    logic [3:0] master_r;                // Master contrast.
    logic [6:0] mux_r;                   // Multiplex ratio minus one.
    logic [1:0] enhance_r;               // Display enhancement field.
    logic lock_r;                        // Command lock.
    logic custom_r;                      // Custom gray table in use.
    logic range_err_r;                   // A loaded width was above the limit.
    logic order_err_r;                   // Loaded widths were not increasing.
    logic [7:0] last_width_r;            // Previous width of the table being loaded.
    logic pready_r;                      // Access phase completion.
    logic [31:0] prdata_r;               // Read data.
    logic pslverr_r;                     // Unmapped access.
    logic [7:0] mem_data_r;              // Display memory data byte.
    logic mem_valid_r;                   // Display memory data strobe.
    logic [7:0] table_rd_data;           // Table word for the bus.
    logic [7:0] table_disp_data;         // Table word for the display.
    logic [7:0] width_out;               // Width from the selector.
    logic wr_take;                       // Write completes this edge.
    logic rd_take;                       // Read data is loaded this edge.
    logic cmd_wr;                        // Command byte arrives.
    logic param_wr;                      // Parameter byte arrives.
    logic [7:0] wbyte;                   // Byte written.
    logic table_wr;                      // Gray table entry written.
    logic [3:0] table_rd_addr;           // Bus read address into the table.

    // Tells whether an address is a known register.
    function automatic logic addr_mapped(input logic [7:0] a, input logic wr);
        logic tbl;
        tbl = (a >= cmd_decoder_pkg::OFS_TABLE) && (a <= cmd_decoder_pkg::OFS_TABLE_END) && (a[1:0] == 2'b00);
        if (wr) begin
            return a == cmd_decoder_pkg::OFS_CMD || a == cmd_decoder_pkg::OFS_PARAM
                || a == cmd_decoder_pkg::OFS_MEMDATA;
        end
        return tbl || a == cmd_decoder_pkg::OFS_STATUS || a == cmd_decoder_pkg::OFS_SET_A
            || a == cmd_decoder_pkg::OFS_SET_B;
    endfunction

    // Number of parameter bytes each command takes.
    function automatic logic [3:0] param_count(input logic [7:0] c);
        case (c)
            cmd_decoder_pkg::CMD_GRAY_TABLE: return 4'(GRAY_LEVELS);
            cmd_decoder_pkg::CMD_ENHANCE: return 4'h2;
            cmd_decoder_pkg::CMD_PRECHARGE2, cmd_decoder_pkg::CMD_PRE_VOLT,
            cmd_decoder_pkg::CMD_DESELECT, cmd_decoder_pkg::CMD_SEG_CURRENT,
            cmd_decoder_pkg::CMD_MASTER, cmd_decoder_pkg::CMD_MUX,
            cmd_decoder_pkg::CMD_LOCK: return 4'h1;
            default: return 4'h0;
        endcase
    endfunction

    // ==========================================================
    // APB slave.
    // ==========================================================
    // Every access has one wait state; writes and reads complete with pready.
    assign wr_take = psel && penable && pwrite && pready_r;
    assign rd_take = psel && penable && !pwrite && !pready_r;
    assign wbyte = pwdata[7:0];
    assign cmd_wr = wr_take && paddr == cmd_decoder_pkg::OFS_CMD;
    assign param_wr = wr_take && paddr == cmd_decoder_pkg::OFS_PARAM;
    assign table_rd_addr = paddr[5:2];

    // Ready rises in the second access cycle and drops right after.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else if (psel && penable && !pready_r) begin
            pready_r <= 1'b1;
            pslverr_r <= !addr_mapped(paddr, pwrite);
        end else begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    // Read data is captured once the table memory has answered.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (rd_take) begin
            prdata_r <= 32'h0000_0000;
            if (paddr >= cmd_decoder_pkg::OFS_TABLE && paddr <= cmd_decoder_pkg::OFS_TABLE_END) begin
                prdata_r[7:0] <= table_rd_data;
            end else if (paddr == cmd_decoder_pkg::OFS_STATUS) begin
                prdata_r[cmd_decoder_pkg::ST_LOCK] <= lock_r;
                prdata_r[cmd_decoder_pkg::ST_CUSTOM] <= custom_r;
                prdata_r[cmd_decoder_pkg::ST_BUSY] <= state_r == PARAMS;
                prdata_r[cmd_decoder_pkg::ST_RANGE] <= range_err_r;
                prdata_r[cmd_decoder_pkg::ST_ORDER] <= order_err_r;
                prdata_r[15:8] <= cmd_decoder_pkg::LOCK_FIXED | {5'h00, lock_r, 2'b00};
            end else if (paddr == cmd_decoder_pkg::OFS_SET_A) begin
                prdata_r <= {precharge2_r, 3'h0, pre_volt_r, 4'h0, deselect_r, 4'h0, seg_current_r};
            end else if (paddr == cmd_decoder_pkg::OFS_SET_B) begin
                prdata_r[19:0] <= {master_r, 1'b0, mux_r, 6'h00, enhance_r};
            end
        end
    end

    // ==========================================================
    // Command parser.
    // ==========================================================
    // Commands are dropped while locked, except the lock command.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= IDLE;
            cmd_r <= 8'h00;
            count_r <= 4'h0;
        end else if (cmd_wr) begin
            if (lock_r && wbyte != cmd_decoder_pkg::CMD_LOCK) begin
                state_r <= DISCARD;
            end else if (param_count(wbyte) != 4'h0) begin
                state_r <= PARAMS;
                cmd_r <= wbyte;
                count_r <= 4'h0;
            end else begin
                state_r <= IDLE;
            end
        end else if (param_wr) begin
            case (state_r)
                PARAMS: begin
                    count_r <= count_r + 4'h1;
                    if (count_r + 4'h1 == param_count(cmd_r)) begin
                        state_r <= DISCARD;
                    end
                end
                default: begin
                    state_r <= state_r;
                end
            endcase
        end
    end

    // The parameterless commands CMD_TABLE_ON and CMD_LINEAR select the table in use.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            custom_r <= 1'b0;
        end else if (cmd_wr && !lock_r) begin
            if (wbyte == cmd_decoder_pkg::CMD_LINEAR) begin
                custom_r <= 1'b0;
            end else if (wbyte == cmd_decoder_pkg::CMD_TABLE_ON) begin
                custom_r <= 1'b1;
            end
        end
    end

    // Single-byte settings keep only their meaningful bits.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            precharge2_r <= cmd_decoder_pkg::RST_PRECHARGE2;
            pre_volt_r <= cmd_decoder_pkg::RST_PRE_VOLT;
            deselect_r <= cmd_decoder_pkg::RST_DESELECT;
            seg_current_r <= cmd_decoder_pkg::RST_SEG_CURRENT;
            master_r <= cmd_decoder_pkg::RST_MASTER;
            mux_r <= cmd_decoder_pkg::RST_MUX;
            lock_r <= 1'b0;
        end else if (param_wr && state_r == PARAMS && count_r == 4'h0) begin
            case (cmd_r)
                cmd_decoder_pkg::CMD_PRECHARGE2: precharge2_r <= wbyte[3:0];
                cmd_decoder_pkg::CMD_PRE_VOLT: pre_volt_r <= wbyte[4:0];
                cmd_decoder_pkg::CMD_DESELECT: deselect_r <= wbyte[3:0];
                cmd_decoder_pkg::CMD_SEG_CURRENT: seg_current_r <= wbyte;
                cmd_decoder_pkg::CMD_MASTER: master_r <= wbyte[3:0];
                cmd_decoder_pkg::CMD_MUX: begin
                    // Ratios below sixteen rows are not served and are dropped.
                    if (wbyte[6:0] >= cmd_decoder_pkg::MUX_MIN) begin
                        mux_r <= wbyte[6:0];
                    end
                end
                cmd_decoder_pkg::CMD_LOCK: lock_r <= wbyte[cmd_decoder_pkg::LOCK_BIT];
                default: begin
                    lock_r <= lock_r;
                end
            endcase
        end
    end

    // Enhancement: the first byte holds the field, the second is fixed.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enhance_r <= cmd_decoder_pkg::RST_ENHANCE;
        end else if (param_wr && state_r == PARAMS && cmd_r == cmd_decoder_pkg::CMD_ENHANCE
                     && count_r == 4'h0) begin
            // The reserved code leaves the setting unchanged.
            if (wbyte[cmd_decoder_pkg::ENHANCE_LSB+:2] != cmd_decoder_pkg::ENHANCE_RESERVED) begin
                enhance_r <= wbyte[cmd_decoder_pkg::ENHANCE_LSB+:2];
            end
        end
    end

    // ==========================================================
    // Gray table loading and checks.
    // ==========================================================
    assign table_wr = param_wr && state_r == PARAMS && cmd_r == cmd_decoder_pkg::CMD_GRAY_TABLE;

    // Flags out-of-range or non-increasing widths; a new table clears them.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            range_err_r <= 1'b0;
            order_err_r <= 1'b0;
            last_width_r <= 8'h00;
        end else if (table_wr) begin
            last_width_r <= wbyte;
            if (wbyte > cmd_decoder_pkg::GRAY_MAX) begin
                range_err_r <= 1'b1;
            end
            if (count_r != 4'h0 && wbyte <= last_width_r) begin
                order_err_r <= 1'b1;
            end
        end else if (cmd_wr && !lock_r && wbyte == cmd_decoder_pkg::CMD_GRAY_TABLE) begin
            range_err_r <= 1'b0;
            order_err_r <= 1'b0;
        end
    end

    // Level n is stored at entry n, in the order the bytes arrive.
    gray_table_mem #(
        .DEPTH(16),
        .WIDTH(8)
    ) u_table (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(table_wr),
        .wr_addr(count_r + 4'h1),
        .wr_data(wbyte),
        .rd_addr_a(table_rd_addr),
        .rd_data_a(table_rd_data),
        .rd_addr_b(gray_level),
        .rd_data_b(table_disp_data)
    );

    // Width for the display's current gray level.
    gray_width_select u_select (
        .pclk(pclk),
        .presetn(presetn),
        .custom_table(custom_r),
        .level(gray_level),
        .custom_width(table_disp_data),
        .width_r(width_out)
    );

    // ==========================================================
    // Display memory writes.
    // ==========================================================
    // Memory data is blocked while the interface is locked.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_data_r <= 8'h00;
            mem_valid_r <= 1'b0;
        end else begin
            mem_valid_r <= wr_take && paddr == cmd_decoder_pkg::OFS_MEMDATA && !lock_r;
            if (wr_take && paddr == cmd_decoder_pkg::OFS_MEMDATA && !lock_r) begin
                mem_data_r <= wbyte;
            end
        end
    end

    // ==========================================================
    // Outputs.
    // ==========================================================
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign gray_level_width = width_out;
    assign mem_data = mem_data_r;
    assign mem_data_valid = mem_valid_r;
    assign settings = '{precharge2: precharge2_r, pre_volt: pre_volt_r, com_deselect_level: deselect_r,
                        segment_drive_current: seg_current_r, master_contrast: master_r, mux_ratio: mux_r,
                        enhance: enhance_r, custom_table: custom_r, locked: lock_r};

endmodule

// *** test/cmd_dec_chk.sv ***
`timescale 1ns/1ps
// ==========
// Port checks for the decoder.
module cmd_dec_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [3:0] gray_level,
    input wire logic [7:0] gray_level_width,
    input wire cmd_decoder_pkg::settings_type settings,
    input wire logic mem_data_valid
);
    // This is high at the edge that completes a parameter write.
    wire pw = psel && penable && pready && pwrite && paddr == cmd_decoder_pkg::OFS_PARAM;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // The access phase has one wait state and then pready.
    sequence s_acc;
        psel && penable && !pready ##1 pready;
    endsequence
    a_ready_wait: assert property (psel && !penable |=> s_acc) else $error("pready late");
    a_pre2_load: assert property ($past(presetn) && $changed(settings.precharge2) |->
        $past(pw) && settings.precharge2 == $past(pwdata[3:0])) else $error("precharge2 load");
    a_seg_load: assert property ($past(presetn) && $changed(settings.segment_drive_current) |->
        $past(pw) && settings.segment_drive_current == $past(pwdata[7:0])) else $error("seg load");
    a_lock_hold: assert property (settings.locked |=> $stable(settings[35:1])) else $error("locked change");
    a_mem_drop: assert property (settings.locked && $past(settings.locked) |-> !mem_data_valid)
        else $error("mem while locked");
    a_mux_floor: assert property (settings.mux_ratio >= cmd_decoder_pkg::MUX_MIN) else $error("mux low");
    a_enh_legal: assert property (settings.enhance != cmd_decoder_pkg::ENHANCE_RESERVED)
        else $error("enhance reserved");
    a_linear_width: assert property ($past(presetn, 2) && $past(presetn) && !settings.custom_table &&
        !$past(settings.custom_table) && !$past(settings.custom_table, 2) |-> gray_level_width ==
        ($past(gray_level, 2) < 4'h2 ? 8'h00 : 8'h08 * ($past(gray_level, 2) - 4'h1))) else $error("linear");
endmodule
bind oled_driver_config_command_decoder cmd_dec_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .gray_level(gray_level),
    .gray_level_width(gray_level_width), .settings(settings), .mem_data_valid(mem_data_valid));

// *** test/host_mcu_model.sv ***
`timescale 1ns/1ps
// ==========
// Host side: one APB byte transfer at a time.
module host_mcu_model (
    input wire logic pclk,
    input wire logic pready,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    // Holds the request until pready is seen, then releases for one edge.
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d; // Released data shows no stale value.
        @(posedge pclk);
    endtask
endmodule

// *** test/tb.sv ***
`timescale 1ns/1ps
// ==========
// Self-checking bench for the decoder.
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, mem_data_valid;
    logic [7:0] paddr, gray_level_width, mem_data;
    logic [31:0] pwdata, prdata;
    logic [3:0] gray_level = 4'h0;
    cmd_decoder_pkg::settings_type settings;
    logic [32:0] exp_q[$]; // Expected error flag and read data.
    logic [31:0] msk_q[$]; // Compared read data bits.
    logic [7:0] mem_q[$]; // Expected display memory bytes.
    logic [7:0] r[5];
    logic [7:0] gw[16];
    int fails = 0;
    int checked = 0;
    initial forever #4 pclk = ~pclk;
    always @(posedge pclk) gray_level <= 4'($urandom);
    host_mcu_model host (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata));
    oled_driver_config_command_decoder u_oled_driver_config_command_decoder (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .gray_level(gray_level), .gray_level_width(gray_level_width),
        .settings(settings), .mem_data(mem_data), .mem_data_valid(mem_data_valid));
    task automatic compare(input string nm, input logic [32:0] e, input logic [32:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Every completed transfer is compared with the oldest note.
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            compare("apb", exp_q.pop_front(), {pslverr, prdata & msk_q.pop_front()});
        end
        if (mem_data_valid !== 1'b0) compare("mem", mem_q.pop_front(), mem_data);
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic e = 1'b0);
        exp_q.push_back({e, 32'h0});
        msk_q.push_back(32'h0);
        host.xfer(1'b1, a, {24'($urandom), d});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic e = 1'b0);
        exp_q.push_back({e, d & m});
        msk_q.push_back(m);
        host.xfer(1'b0, a, 32'h0);
    endtask
    task automatic cmd(input logic [7:0] c);
        wr(cmd_decoder_pkg::OFS_CMD, c);
    endtask
    task automatic prm(input logic [7:0] p);
        wr(cmd_decoder_pkg::OFS_PARAM, p);
    endtask
    task automatic finish_test;
        fails += mem_q.size();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        finish_test;
    end
    // ==========
    // Main sequence.
    initial begin
        void'($urandom(32'hDE5E));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(8'h10, 32'h8170407F, 32'hF1F0F0FF);
        rd(8'h14, 32'h000F7F02, 32'h000F7F03);
        rd(8'h0C, 32'h00001200, 32'h0000FF1F);
        foreach (r[i]) r[i] = 8'($urandom);
        foreach (r[i]) cmd(i == 0 ? 8'hB6 : i == 1 ? 8'hBB : i == 2 ? 8'hBE : i == 3 ? 8'hC1 : 8'hC7);
        cmd(8'hB6); prm(r[0]); cmd(8'hBB); prm(r[1]); cmd(8'hBE); prm(r[2]); cmd(8'hC1); prm(r[3]);
        cmd(8'hC7); prm(r[4]); cmd(8'hCA); prm(8'h0E); cmd(8'hCA); prm(8'h8F);
        cmd(8'hD1); prm(8'h00); prm(8'h20); cmd(8'hD1); prm(8'h10); prm(8'h20);
        rd(8'h10, {r[0][3:0], 3'h0, r[1][4:0], 4'h0, r[2][3:0], 4'h0, r[3]}, 32'hF1F0F0FF);
        rd(8'h14, {12'h0, r[4][3:0], 1'b0, 7'h0F, 6'h0, 2'h1}, 32'h000F7F03);
        cmd(8'hB8);
        for (int n = 1; n <= 15; n++) begin
            gw[n] = 8'(12 * n - $urandom_range(3));
            prm(gw[n]);
        end
        prm(8'h01);
        cmd(8'h00);
        for (int n = 1; n <= 15; n++) rd(8'(8'h40 + 4 * n), {24'h0, gw[n]}, 32'h000000FF);
        rd(8'h0C, 32'h00000002, 32'h0000001F);
        cmd(8'hB9);
        rd(8'h0C, 32'h00000000, 32'h00000002);
        cmd(8'hFD); prm(8'h16); cmd(8'hC1); prm(~r[3]); wr(8'h08, r[0]);
        rd(8'h0C, 32'h00001601, 32'h0000FF01);
        cmd(8'hFD); prm(8'h12); mem_q.push_back(r[1]); wr(8'h08, r[1]);
        rd(8'h10, {24'h0, r[3]}, 32'h000000FF);
        wr(8'h0C, 8'h00, 1'b1);
        rd(8'h20, 32'h0, 32'h0, 1'b1);
        finish_test;
    end
endmodule
